// file: design/inband_status_regs.sv
// in-band status flags, indicator pin override and pad drive registers behind an apb slave
// assumes the frame parser, executor and responder run on pclk and give one-cycle pulses
// Overview of operation
// - a valid in-band frame sets the good-frame flag, bit 31.
// - sending the response frame sets the response-sent flag, bit 30.
// - finishing all commands of a frame sets the execution-done flag, bit 29.
// - a frame with matching tag clears response, execution and error flags; software cannot.
// - address-mismatch flag, bit 14, only while destination checking is enabled.
// - access format other than 0x9800 sets the format error flag, bit 13.
// - access code other than 0x0001 or 0x0002 sets the code error flag, bit 12.
// - an unrecognised command code sets the command error flag, bit 11.
// - frames above 320 bytes, pad and fcs included, set the oversize flag, bit 10.
// - an oversized frame gets no response frame.
// - bits 6:0 give the position of the unrecognised command code.
// - override bits 9:0 map to indicator pins, group 1 first pin upward.
// - override bit 0 shows link status; 1 makes the pin a general output.
// - the output level bit drives a general output pin low or high.
// - with checking enabled, frames to another destination address are discarded.
//
// Added by the designer: the APB slave port.
module inband_status_regs (
   input  wire logic                                 pclk,
   input  wire logic                                 presetn,
   input  wire logic [inband_regs_pkg::ADDR_W-1:0]   paddr,
   input  wire logic                                 psel,
   input  wire logic                                 penable,
   input  wire logic                                 pwrite,
   input  wire logic [31:0]                          pwdata,
   output logic      [31:0]                          prdata,
   output logic                                      pready,
   output logic                                      pslverr,
   input  wire logic [47:0]                          switch_mac,
   input  wire logic                                 frame_end,
   input  wire logic                                 frame_tag_match,
   input  wire logic [47:0]                          frame_dest_mac,
   input  wire logic [15:0]                          frame_format,
   input  wire logic [15:0]                          frame_code,
   input  wire logic [15:0]                          frame_len,
   input  wire logic                                 frame_cmd_unknown,
   input  wire logic [inband_regs_pkg::POS_W-1:0]    frame_cmd_pos,
   input  wire logic                                 resp_sent,
   input  wire logic                                 exec_done,
   output logic                                      frame_discard,
   output logic                                      resp_inhibit,
   output logic                                      dest_addr_check_enable,
   input  wire logic [inband_regs_pkg::NUM_PINS-1:0] link_activity,
   output logic      [inband_regs_pkg::NUM_PINS-1:0] indicator_pin,
   output logic      [7:0]                           pad_drive_strength
);

   localparam int NP = inband_regs_pkg::NUM_PINS;
   localparam int PW = inband_regs_pkg::POS_W;

   // address decode shared by the read and the write path
   function automatic inband_regs_pkg::reg_sel_t reg_hit(
      input logic [inband_regs_pkg::ADDR_W-1:0] addr);
      if (addr == inband_regs_pkg::ADDR_CHECK_CTRL) begin
         return inband_regs_pkg::SEL_CTRL;
      end else if (addr == inband_regs_pkg::ADDR_PAD_DRIVE) begin
         return inband_regs_pkg::SEL_PAD;
      end else if (addr == inband_regs_pkg::ADDR_STATUS) begin
         return inband_regs_pkg::SEL_STATUS;
      end else if (addr == inband_regs_pkg::ADDR_OVERRIDE) begin
         return inband_regs_pkg::SEL_OVR;
      end else if (addr == inband_regs_pkg::ADDR_LEVEL) begin
         return inband_regs_pkg::SEL_LEVEL;
      end else begin
         return inband_regs_pkg::SEL_NONE;
      end
   endfunction

   frame_check_if chk ();

   inband_frame_check u_check (
      .check_enable      (dest_addr_check_enable),
      .switch_mac        (switch_mac),
      .frame_dest_mac    (frame_dest_mac),
      .frame_format      (frame_format),
      .frame_code        (frame_code),
      .frame_len         (frame_len),
      .frame_cmd_unknown (frame_cmd_unknown),
      .frame_cmd_pos     (frame_cmd_pos),
      .chk               (chk)
   );

   // registered state
   logic          good_flag;
   logic          resp_flag;
   logic          exec_flag;
   logic [4:0]    err_flags;     // addr, fmt, code, cmd, size from high to low
   logic [PW-1:0] cmd_pos;
   logic [NP-1:0] override_sel;
   logic [NP-1:0] output_level;

   logic          next_good_flag;
   logic          next_resp_flag;
   logic          next_exec_flag;
   logic [4:0]    next_err_flags;
   logic [PW-1:0] next_cmd_pos;
   logic [NP-1:0] next_override_sel;
   logic [NP-1:0] next_output_level;
   logic [7:0]    next_pad_drive_strength;
   logic          next_check_enable;
   logic [31:0]   next_prdata;
   logic          next_frame_discard;
   logic          next_resp_inhibit;
   logic [NP-1:0] next_indicator_pin;

   logic                      frame_clear;
   logic [4:0]                frame_errs;
   logic                      wr_access;
   logic                      setup_phase;
   inband_regs_pkg::reg_sel_t sel;
   logic [31:0]               status_word;

   assign sel         = reg_hit(paddr);
   assign setup_phase = psel && !penable;
   assign wr_access   = psel && penable && pwrite;

   // zero wait states: the answer is ready in the first access cycle
   assign pready  = psel && penable;
   assign pslverr = psel && penable && (sel == inband_regs_pkg::SEL_NONE);

   assign frame_clear = frame_end && frame_tag_match;
   assign frame_errs  = {chk.addr_err, chk.fmt_err, chk.code_err, chk.cmd_err, chk.size_err};

   // status word; reserved bits 28:15 and 9:7 read zero
   always_comb begin
      status_word                                     = 32'h0000_0000;
      status_word[inband_regs_pkg::BIT_GOOD]          = good_flag;
      status_word[inband_regs_pkg::BIT_RESP]          = resp_flag;
      status_word[inband_regs_pkg::BIT_EXEC]          = exec_flag;
      status_word[inband_regs_pkg::BIT_ADDR_ERR]      = err_flags[4];
      status_word[inband_regs_pkg::BIT_FMT_ERR]       = err_flags[3];
      status_word[inband_regs_pkg::BIT_CODE_ERR]      = err_flags[2];
      status_word[inband_regs_pkg::BIT_CMD_ERR]       = err_flags[1];
      status_word[inband_regs_pkg::BIT_SIZE_ERR]      = err_flags[0];
      status_word[inband_regs_pkg::POS_LSB +: PW]     = cmd_pos;
   end

   // indicator pin source per pin, pin 0 is the first pin of group 1
   genvar gi;
   generate
      for (gi = 0; gi < NP; gi++) begin : g_pin
         assign next_indicator_pin[gi] = override_sel[gi] ? output_level[gi]
                                                          : link_activity[gi];
      end
   endgenerate

   // next values of flags, software registers and read data
   always_comb begin
      // a set in the same cycle as the tag clear wins, so no event is lost
      next_good_flag = good_flag | (frame_end && !chk.discard && (frame_errs == 5'h00));
      next_resp_flag = (resp_flag && !frame_clear) || resp_sent;
      next_exec_flag = (exec_flag && !frame_clear) || exec_done;
      next_err_flags = (err_flags & ~{5{frame_clear}})
                       | (frame_errs & {5{frame_end}});
      next_cmd_pos   = frame_clear ? {PW{1'h0}} : cmd_pos;
      if (frame_end && chk.cmd_err) begin
         next_cmd_pos = chk.cmd_pos;
      end
      // verdicts go out one cycle after the frame end
      next_frame_discard = frame_end && chk.discard;
      next_resp_inhibit  = frame_end && chk.size_err;

      next_override_sel       = override_sel;
      next_output_level       = output_level;
      next_pad_drive_strength = pad_drive_strength;
      next_check_enable       = dest_addr_check_enable;
      // the status register has no write path, software cannot clear it
      if (wr_access) begin
         case (sel)
            inband_regs_pkg::SEL_CTRL: begin
               next_check_enable = pwdata[inband_regs_pkg::BIT_CHECK_EN];
            end
            inband_regs_pkg::SEL_PAD: begin
               next_pad_drive_strength = pwdata[7:0];
            end
            inband_regs_pkg::SEL_OVR: begin
               next_override_sel = pwdata[NP-1:0];
            end
            inband_regs_pkg::SEL_LEVEL: begin
               next_output_level = pwdata[NP-1:0];
            end
            default: begin
               next_override_sel = override_sel;
            end
         endcase
      end

      // read data is captured in the setup cycle; reading never touches the flags
      next_prdata = prdata;
      if (setup_phase) begin
         next_prdata = 32'h0000_0000;
         case (sel)
            inband_regs_pkg::SEL_CTRL: begin
               next_prdata[inband_regs_pkg::BIT_CHECK_EN] = dest_addr_check_enable;
            end
            inband_regs_pkg::SEL_PAD: begin
               next_prdata[7:0] = pad_drive_strength;
            end
            inband_regs_pkg::SEL_STATUS: begin
               next_prdata = status_word;
            end
            inband_regs_pkg::SEL_OVR: begin
               next_prdata[NP-1:0] = override_sel;
            end
            inband_regs_pkg::SEL_LEVEL: begin
               next_prdata[NP-1:0] = output_level;
            end
            default: begin
               next_prdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // registers only; every status field starts at zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         good_flag              <= 1'h0;
         resp_flag              <= 1'h0;
         exec_flag              <= 1'h0;
         err_flags              <= 5'h00;
         cmd_pos                <= 7'h00;
         override_sel           <= inband_regs_pkg::OVERRIDE_RESET;
         output_level           <= inband_regs_pkg::LEVEL_RESET;
         pad_drive_strength     <= inband_regs_pkg::PAD_DRIVE_RESET;
         dest_addr_check_enable <= inband_regs_pkg::CHECK_EN_RESET;
         prdata                 <= 32'h0000_0000;
         frame_discard          <= 1'h0;
         resp_inhibit           <= 1'h0;
         indicator_pin          <= 10'h000;
      end else begin
         good_flag              <= next_good_flag;
         resp_flag              <= next_resp_flag;
         exec_flag              <= next_exec_flag;
         err_flags              <= next_err_flags;
         cmd_pos                <= next_cmd_pos;
         override_sel           <= next_override_sel;
         output_level           <= next_output_level;
         pad_drive_strength     <= next_pad_drive_strength;
         dest_addr_check_enable <= next_check_enable;
         prdata                 <= next_prdata;
         frame_discard          <= next_frame_discard;
         resp_inhibit           <= next_resp_inhibit;
         indicator_pin          <= next_indicator_pin;
      end
   end

   // checks on the flag and pin behaviour
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_clean_frame;
      frame_end && !chk.discard && !frame_cmd_unknown
      && (frame_format == inband_regs_pkg::ACCESS_FORMAT)
      && (frame_len <= inband_regs_pkg::MAX_FRAME_BYTES)
      && ((frame_code == inband_regs_pkg::ACCESS_CODE_0)
          || (frame_code == inband_regs_pkg::ACCESS_CODE_1));
   endsequence

   sequence s_gpo_high;
      (override_sel == 10'h3ff) && (output_level == 10'h3ff);
   endsequence

   sequence s_gpo_low;
      (override_sel == 10'h3ff) && (output_level == 10'h000);
   endsequence

   AST_GOOD_SET: assert property (
      s_clean_frame |=> status_word[31] && (err_flags == 5'h00))
      else $error("clean frame did not set the good flag");

   AST_RESP_SET: assert property (
      resp_sent |=> resp_flag ##1 (resp_flag || $past(frame_clear)))
      else $error("response sent flag not set");

   AST_EXEC_SET: assert property (
      exec_done |=> status_word[29])
      else $error("execution done flag not set");

   AST_TAG_CLEAR: assert property (
      (frame_clear && !resp_sent && !exec_done) and s_clean_frame
      |=> !resp_flag && !exec_flag && (status_word[14:10] == 5'h00) && (cmd_pos == 7'h00))
      else $error("matching tag did not clear the flags");

   AST_ADDR_ERR_GATED: assert property (
      $rose(err_flags[4]) |-> $past(dest_addr_check_enable) && $past(frame_end))
      else $error("address mismatch flagged while checking was off");

   AST_FORMAT_ERR: assert property (
      frame_end && !chk.discard && (frame_format != 16'h9800) |=> status_word[13])
      else $error("format error not flagged");

   AST_CODE_ERR: assert property (
      frame_end && !chk.discard && (frame_code > 16'h0002) |=> status_word[12])
      else $error("access code error not flagged");

   AST_CMD_POS: assert property (
      frame_end && frame_cmd_unknown && !chk.discard
      |=> status_word[11] && (status_word[6:0] == $past(frame_cmd_pos)))
      else $error("command error position wrong");

   AST_OVERSIZE: assert property (
      frame_end && !chk.discard && (frame_len > 16'h0140)
      |=> status_word[10] && resp_inhibit ##1 (!resp_inhibit || $past(frame_end)))
      else $error("oversize frame not flagged or response not inhibited");

   AST_DISCARD: assert property (
      frame_end && dest_addr_check_enable && (frame_dest_mac != switch_mac)
      |=> frame_discard && !$rose(good_flag))
      else $error("mismatched frame not discarded");

   AST_GPO_LEVEL: assert property (
      s_gpo_high ##1 s_gpo_high |-> (indicator_pin == 10'h3ff))
      else $error("general output pins not driven high");

   AST_GPO_LOW: assert property (
      s_gpo_low ##1 s_gpo_low |-> (indicator_pin == 10'h000))
      else $error("general output pins not driven low");

   AST_READ_NO_EFFECT: assert property (
      pready && !pwrite && !frame_end && !resp_sent && !exec_done
      |=> $stable(status_word))
      else $error("status read changed the flags");

endmodule // inband_status_regs

// file: design/inband_regs_pkg.sv
// constants, register map and field layout of the in-band status and indicator registers
// assumes a 32-bit APB slave on the switch system clock
package inband_regs_pkg;

   localparam int ADDR_W   = 14;   // byte address width of the register window
   localparam int NUM_PINS = 10;   // indicator pins that can become general outputs
   localparam int POS_W    = 7;    // width of the bad command position field

   // printed offsets are register indices; the byte address is four times the index
   localparam logic [11:0] IDX_CHECK_CTRL = 12'h104;
   localparam logic [11:0] IDX_PAD_DRIVE  = 12'h10d;
   localparam logic [11:0] IDX_STATUS     = 12'h110;
   localparam logic [11:0] IDX_OVERRIDE   = 12'h120;
   localparam logic [11:0] IDX_LEVEL      = 12'h124;

   localparam logic [ADDR_W-1:0] ADDR_CHECK_CTRL = {IDX_CHECK_CTRL, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_PAD_DRIVE  = {IDX_PAD_DRIVE, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_STATUS     = {IDX_STATUS, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_OVERRIDE   = {IDX_OVERRIDE, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_LEVEL      = {IDX_LEVEL, 2'h0};

   // status register bit positions
   localparam int BIT_GOOD     = 31;
   localparam int BIT_RESP     = 30;
   localparam int BIT_EXEC     = 29;
   localparam int BIT_ADDR_ERR = 14;
   localparam int BIT_FMT_ERR  = 13;
   localparam int BIT_CODE_ERR = 12;
   localparam int BIT_CMD_ERR  = 11;
   localparam int BIT_SIZE_ERR = 10;
   localparam int POS_LSB      = 0;

   // control register bit for destination address checking
   localparam int BIT_CHECK_EN = 30;

   // reset values
   localparam logic [7:0]          PAD_DRIVE_RESET = 8'h62;
   localparam logic                CHECK_EN_RESET  = 1'h0;
   localparam logic [NUM_PINS-1:0] OVERRIDE_RESET  = 10'h000;
   localparam logic [NUM_PINS-1:0] LEVEL_RESET     = 10'h000;

   // frame field values
   localparam logic [15:0] ACCESS_FORMAT   = 16'h9800;
   localparam logic [15:0] ACCESS_CODE_0   = 16'h0001;
   localparam logic [15:0] ACCESS_CODE_1   = 16'h0002;
   localparam logic [15:0] MAX_FRAME_BYTES = 16'h0140;   // 320, with the zero pad and fcs

   typedef enum logic [2:0] {
      SEL_NONE   = 3'h0,
      SEL_CTRL   = 3'h1,
      SEL_PAD    = 3'h3,
      SEL_STATUS = 3'h2,
      SEL_OVR    = 3'h6,
      SEL_LEVEL  = 3'h7
   } reg_sel_t;

endpackage

// file: design/frame_check_if.sv
// verdict on one received in-band frame, passed from the checker to the register bank
// assumes both ends sit on the same clock; the verdict is combinational
interface frame_check_if;
   logic                                addr_err;
   logic                                fmt_err;
   logic                                code_err;
   logic                                cmd_err;
   logic                                size_err;
   logic                                discard;
   logic [inband_regs_pkg::POS_W-1:0]   cmd_pos;

   modport judge   (output addr_err, fmt_err, code_err, cmd_err, size_err, discard, cmd_pos);
   modport regs    (input  addr_err, fmt_err, code_err, cmd_err, size_err, discard, cmd_pos);
endinterface

// file: design/inband_frame_check.sv
// classifies the header fields of one in-band frame into error causes
// assumes the parser holds the fields stable while frame_end is high
module inband_frame_check (
   input  wire logic                              check_enable,
   input  wire logic [47:0]                       switch_mac,
   input  wire logic [47:0]                       frame_dest_mac,
   input  wire logic [15:0]                       frame_format,
   input  wire logic [15:0]                       frame_code,
   input  wire logic [15:0]                       frame_len,
   input  wire logic                              frame_cmd_unknown,
   input  wire logic [inband_regs_pkg::POS_W-1:0] frame_cmd_pos,
   frame_check_if.judge                           chk
);

   // a discarded frame reports only the mismatch, nothing it carries is judged
   always_comb begin
      chk.discard  = check_enable && (frame_dest_mac != switch_mac);
      chk.addr_err = chk.discard;
      chk.fmt_err  = !chk.discard && (frame_format != inband_regs_pkg::ACCESS_FORMAT);
      chk.code_err = !chk.discard && (frame_code != inband_regs_pkg::ACCESS_CODE_0)
                     && (frame_code != inband_regs_pkg::ACCESS_CODE_1);
      chk.cmd_err  = !chk.discard && frame_cmd_unknown;
      chk.size_err = !chk.discard && (frame_len > inband_regs_pkg::MAX_FRAME_BYTES);
      chk.cmd_pos  = frame_cmd_pos;
   end

endmodule // inband_frame_check

// file: testbench/inband_status_and_led_gpo_regs_test.sv
// self-checking bench for the in-band status, indicator override and pad drive registers
// assumes zero-wait apb answers and one-cycle frame and event pulses, all on pclk
module inband_status_and_led_gpo_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [13:0] paddr = 14'h0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err;
   logic [47:0] mac = 48'h0, frame_dest_mac = 48'h0;
   logic        frame_end = 1'b0, frame_tag_match = 1'b0, frame_cmd_unknown = 1'b0;
   logic [15:0] frame_format = 16'h0, frame_code = 16'h0, frame_len = 16'h0;
   logic [6:0]  frame_cmd_pos = 7'h0;
   logic        resp_sent = 1'b0, exec_done = 1'b0;
   logic        frame_discard, resp_inhibit, dest_addr_check_enable;
   logic [9:0]  link_activity = 10'h0, indicator_pin, ovr, lvl;
   logic [7:0]  pad_drive_strength;
   logic [31:0] st = 32'h0;   // model of the status word
   logic        chk_en = 1'b0;
   int          err_total = 0, n_checks = 0;

   always #10 pclk = ~pclk;

   inband_status_regs i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .switch_mac(mac), .frame_end(frame_end),
      .frame_tag_match(frame_tag_match), .frame_dest_mac(frame_dest_mac),
      .frame_format(frame_format), .frame_code(frame_code), .frame_len(frame_len),
      .frame_cmd_unknown(frame_cmd_unknown), .frame_cmd_pos(frame_cmd_pos),
      .resp_sent(resp_sent), .exec_done(exec_done), .frame_discard(frame_discard),
      .resp_inhibit(resp_inhibit), .dest_addr_check_enable(dest_addr_check_enable),
      .link_activity(link_activity), .indicator_pin(indicator_pin),
      .pad_drive_strength(pad_drive_strength));

   // one closing point for the normal end and for an exhausted wait
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // apb transfer; request held until pready is sampled high, bounded wait
   task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= wr; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         err_total++;
         give_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic rd_chk(input string what, input logic [13:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, rd, exp);
   endtask

   // one received frame; other selects a foreign destination address
   task automatic frame(input logic tag, input logic other, input logic [15:0] fmt,
                        input logic [15:0] code, input logic [15:0] len, input logic unk);
      logic [6:0] pos;
      logic       disc, big, bad;
      pos  = 7'($urandom);
      disc = chk_en && other;
      big  = !disc && len > 16'h0140;
      @(posedge pclk);
      frame_end <= 1'b1; frame_tag_match <= tag; frame_dest_mac <= other ? ~mac : mac;
      frame_format <= fmt; frame_code <= code; frame_len <= len;
      frame_cmd_unknown <= unk; frame_cmd_pos <= pos;
      @(posedge pclk);
      frame_end <= 1'b0;
      #1;
      chk("discard", 32'(frame_discard), 32'(disc));
      chk("inhibit", 32'(resp_inhibit), 32'(big));
      if (tag) st = st & ~32'h6000_7c7f;
      if (disc) st[14] = 1'b1;
      else begin
         bad = 1'b0;
         if (fmt != 16'h9800) begin st[13] = 1'b1; bad = 1'b1; end
         if (code != 16'h0001 && code != 16'h0002) begin st[12] = 1'b1; bad = 1'b1; end
         if (unk) begin st[11] = 1'b1; st[6:0] = pos; bad = 1'b1; end
         if (big) begin st[10] = 1'b1; bad = 1'b1; end
         if (!bad) st[31] = 1'b1;
      end
      rd_chk("status", inband_regs_pkg::ADDR_STATUS, st);
   endtask

   // one-cycle event pulse from the responder or the executor
   task automatic event_pulse(input logic is_resp);
      @(posedge pclk);
      resp_sent <= is_resp; exec_done <= !is_resp;
      @(posedge pclk);
      resp_sent <= 1'b0; exec_done <= 1'b0;
      st[is_resp ? 30 : 29] = 1'b1;
      rd_chk("status", inband_regs_pkg::ADDR_STATUS, st);
   endtask

   initial begin
      void'($urandom(32'hc89e1632));
      mac = {16'($urandom), 32'($urandom)};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      // reset values of every register, then an unmapped place
      rd_chk("ctrl", inband_regs_pkg::ADDR_CHECK_CTRL, 32'h0);
      rd_chk("pad", inband_regs_pkg::ADDR_PAD_DRIVE, 32'h62);
      rd_chk("status", inband_regs_pkg::ADDR_STATUS, 32'h0);
      rd_chk("override", inband_regs_pkg::ADDR_OVERRIDE, 32'h0);
      rd_chk("level", inband_regs_pkg::ADDR_LEVEL, 32'h0);
      rd_chk("unmapped", 14'h0004, 32'h0);
      chk("unmapped err", 32'(err), 32'h1);
      apb(1'b1, 14'h0004, 32'hffff_ffff);
      chk("unmapped werr", 32'(err), 32'h1);
      apb(1'b1, inband_regs_pkg::ADDR_PAD_DRIVE, 32'h0000_00a5);
      rd_chk("pad", inband_regs_pkg::ADDR_PAD_DRIVE, 32'ha5);
      chk("pad port", 32'(pad_drive_strength), 32'ha5);
      // indicator pins: random override, level and link status
      repeat (8) begin
         ovr = 10'($urandom); lvl = 10'($urandom);
         link_activity <= 10'($urandom);
         apb(1'b1, inband_regs_pkg::ADDR_OVERRIDE, {22'h3fffff, ovr});
         apb(1'b1, inband_regs_pkg::ADDR_LEVEL, {22'h3fffff, lvl});
         repeat (3) @(posedge pclk);
         #1;
         chk("pins", 32'(indicator_pin), 32'((ovr & lvl) | (~ovr & link_activity)));
         rd_chk("override", inband_regs_pkg::ADDR_OVERRIDE, {22'h0, ovr});
      end
      // all pins as general outputs, driven high and then low
      apb(1'b1, inband_regs_pkg::ADDR_OVERRIDE, 32'h0000_03ff);
      apb(1'b1, inband_regs_pkg::ADDR_LEVEL, 32'h0000_03ff);
      repeat (3) @(posedge pclk);
      #1;
      chk("pins high", 32'(indicator_pin), 32'h0000_03ff);
      apb(1'b1, inband_regs_pkg::ADDR_LEVEL, 32'h0000_0000);
      repeat (3) @(posedge pclk);
      #1;
      chk("pins low", 32'(indicator_pin), 32'h0000_0000);
      // frames with checking off: a foreign address is ignored
      frame(1'b1, 1'b0, 16'h9800, 16'h0001, 16'h0040, 1'b0);
      frame(1'b0, 1'b1, 16'h1234, 16'h0002, 16'h0140, 1'b0);
      apb(1'b1, inband_regs_pkg::ADDR_CHECK_CTRL, 32'h4000_0000);
      chk_en = 1'b1;
      // the enable register updates at the edge that ends the write
      #1;
      chk("check en", 32'(dest_addr_check_enable), 32'h1);
      event_pulse(1'b1);
      event_pulse(1'b0);
      frame(1'b1, 1'b0, 16'h9800, 16'h0000, 16'h0040, 1'b0);
      frame(1'b1, 1'b0, 16'h9800, 16'h0003, 16'h0141, 1'b1);
      frame(1'b0, 1'b0, 16'h9800, 16'h0002, 16'h0140, 1'b1);
      // software cannot clear status, and reading has no side effect
      apb(1'b1, inband_regs_pkg::ADDR_STATUS, 32'h0);
      chk("status werr", 32'(err), 32'h0);
      rd_chk("status", inband_regs_pkg::ADDR_STATUS, st);
      rd_chk("status", inband_regs_pkg::ADDR_STATUS, st);
      frame(1'b1, 1'b1, 16'h0000, 16'h0000, 16'h0200, 1'b1);
      frame(1'b1, 1'b0, 16'h9800, 16'h0002, 16'hffff, 1'b0);
      frame(1'b1, 1'b0, 16'h9800, 16'h0001, 16'h0020, 1'b0);
      // reset in mid-run brings the status, control and pad drive registers back to their reset values
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      st = 32'h0;
      chk_en = 1'b0;
      rd_chk("status", inband_regs_pkg::ADDR_STATUS, st);
      rd_chk("ctrl", inband_regs_pkg::ADDR_CHECK_CTRL, 32'h0);
      rd_chk("pad", inband_regs_pkg::ADDR_PAD_DRIVE, 32'h62);
      give_verdict();
   end
endmodule // inband_status_and_led_gpo_regs_test
